/* File: logic/stcc_regs.svh */
// codes, offsets and reset values of the custom command block
`ifndef STCC_REGS_SVH
`define STCC_REGS_SVH

`define STCC_PREFIX       8'he0
`define STCC_CODE_CAL     8'ha9
`define STCC_CODE_BATT    8'haa
`define STCC_CODE_SHELF   8'hab
`define STCC_CODE_INIT    8'hac
`define STCC_CODE_SENSOR  8'had
`define STCC_CODE_OPEN    8'hae
`define STCC_CODE_FIFO    8'haf
`define STCC_RETRIG_REQ   8'h01
`define STCC_SUB_READ     3'b100
`define STCC_SUB_WRITE    3'b101
`define STCC_SUB_STAT     3'b110
`define STCC_SEL_BATT     2'b11
`define STCC_FIFO_DEPTH   4'h8
`define STCC_FRAME_MAX    5'h10
`define STCC_TRAILER_LEN  5'h04
`define STCC_FIXED_LEN    5'h06

`define STCC_OFF_CTRL     8'h00
`define STCC_OFF_STAT     8'h04
`define STCC_OFF_SHELF_A  8'h08
`define STCC_OFF_SHELF_B  8'h0c
`define STCC_OFF_LOGCFG   8'h10
`define STCC_OFF_SYSSTAT  8'h14
`define STCC_OFF_LIMIT    8'h18
`define STCC_OFF_PWD_SYS  8'h1c
`define STCC_OFF_PWD_APP  8'h20
`define STCC_OFF_PWD_MEAS 8'h24
`define STCC_OFF_CMDCNT   8'h28

`define STCC_CTRL_RST     32'h0000_0001
`define STCC_PWD_RST      32'h0000_0000
`define STCC_CRC_PRESET   16'hffff
`define STCC_CRC_POLY     16'h1021

`endif

/* File: logic/stcc_pkg.sv */
// types of the custom command block
package stcc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EXEC = 3'b001,
        ST_ADC  = 3'b010,
        ST_GO   = 3'b011,
        ST_WAIT = 3'b100
    } stcc_state_e;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_DATA  = 2'b01,
        TX_CRC   = 2'b10,
        TX_DUMMY = 2'b11
    } stcc_tx_e;

    typedef struct packed {
        logic [7:0] t_max;
        logic [7:0] t_min;
        logic [7:0] t_ref;
        logic [7:0] activation_energy;
    } stcc_shelf_a_s;

    typedef struct packed {
        logic [15:0] initial_shelf_life;
        logic [9:0]  t_init;
        logic [1:0]  sensor_sel;
        logic        neg_life_en;
        logic        algo_en;
        logic [1:0]  reserved_bits;
    } stcc_shelf_b_s;

    typedef struct packed {
        logic [11:0] delay_count;
        logic [1:0]  reserved_bits;
        logic        delay_src;
        logic        irq_timer_en;
    } stcc_delay_s;

    typedef struct packed {
        logic [8:0] app_words;
        logic [3:0] reserved_bits;
        logic [2:0] broken_ptr;
    } stcc_app_s;

endpackage

/* File: logic/stcc_reply_if.sv */
// carrier between command sequencer and reply serialiser
`timescale 1ns/100ps
interface stcc_reply_if;
    logic        start;
    logic [71:0] payload;
    logic [6:0]  plen;
    logic [15:0] handle;
    logic        busy;

    modport seq (output start, output payload, output plen, output handle, input busy);
    modport ser (input start, input payload, input plen, input handle, output busy);
endinterface

/* File: logic/stcc_reply_tx.sv */
// reply serialiser: header, payload, handle, crc-16, dummy bit
`timescale 1ns/100ps
`include "stcc_regs.svh"
module stcc_reply_tx
    import stcc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    stcc_reply_if.ser rif,
    output logic      tx_bit,
    output logic      tx_valid,
    output logic      tx_last,
    input  wire logic tx_ready
);
    stcc_tx_e    phase_r;
    logic [88:0] sh_r;
    logic [6:0]  cnt_r;
    logic [15:0] crc_r;
    logic        fire;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `STCC_CRC_POLY : 16'h0000);
    endfunction

    assign fire     = tx_valid && tx_ready;
    assign tx_valid = (phase_r != TX_IDLE);
    assign tx_last  = (phase_r == TX_DUMMY);
    assign rif.busy = (phase_r != TX_IDLE);

    always_comb begin
        case (phase_r)
            TX_DATA:  tx_bit = sh_r[88];
            TX_CRC:   tx_bit = ~crc_r[15];
            default:  tx_bit = 1'b1;
        endcase
    end

    // handle rides right behind the payload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= TX_IDLE;
            sh_r    <= '0;
            cnt_r   <= '0;
        end else if (phase_r == TX_IDLE) begin
            if (rif.start) begin
                phase_r <= TX_DATA;
                sh_r    <= {1'b0, rif.payload, 16'h0000}
                           | ({73'h0, rif.handle} << (7'd72 - rif.plen));
                cnt_r   <= 7'(rif.plen + 7'd17);
            end
        end else if (fire) begin
            case (phase_r)
                TX_DATA: begin
                    sh_r  <= {sh_r[87:0], 1'b0};
                    cnt_r <= 7'(cnt_r - 7'd1);
                    if (cnt_r == 7'd1) begin
                        phase_r <= TX_CRC;
                        cnt_r   <= 7'd16;
                    end
                end
                TX_CRC: begin
                    cnt_r <= 7'(cnt_r - 7'd1);
                    if (cnt_r == 7'd1) begin
                        phase_r <= TX_DUMMY;
                    end
                end
                default: phase_r <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_r <= `STCC_CRC_PRESET;
        end else if (phase_r == TX_IDLE) begin
            crc_r <= `STCC_CRC_PRESET;
        end else if (fire && phase_r == TX_DATA) begin
            crc_r <= crc_step(crc_r, sh_r[88]);
        end else if (fire && phase_r == TX_CRC) begin
            crc_r <= {crc_r[14:0], 1'b0};
        end
    end
endmodule // stcc_reply_tx

/* File: logic/stcc_cmd.sv */
// custom command interpreter with apb register file and shared byte fifo
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "stcc_regs.svh"
// Functional notes
// - frames start E0 plus code, end handle and crc; reply 0, handle, crc, 1
// - calibration read answers seven calibration bytes then two front-end bytes
// - code AA with retrigger byte starts a battery conversion before replying
// - battery reply: error bit, type bit, four zeros, ten-bit level
// - retrigger 01 requests battery type check, 00 otherwise
// - first shelf word: max, min, reference temperature, activation energy
// - second shelf word: life, initial temp, sensor, negative, enable, reserved
// - code AC zeroes status and limits, stores delay and app words
// - delay word: 12-bit count, reserved, source bit, interrupt-timer enable
// - app word: 9-bit word count, reserved, 3-bit broken-word pointer
// - code AD converts the selected sensor and returns the result
// - sensor reply: error bit, five-bit range or limit, ten-bit value
// - code AE with level and password opens a protected area
// - only level bits 1-0 count: 01 system, 10 app, 11 measurement
// - code AF subcommand with up to eight bytes reaches the fifo
// - subcommand 101 writes, 110 reads status, bits 3-0 give byte count
// - fifo status: busy, ready, empty, source, count 0 to 8
module stcc_cmd
    import stcc_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [7:0]    rx_byte,
    input  wire logic          rx_valid,
    input  wire logic          rx_end,
    input  wire logic          rx_crc_ok,
    input  wire logic [55:0]   cal_data,
    input  wire logic [15:0]   sfe_params,
    output logic               adc_start,
    output logic [1:0]         adc_sel,
    output logic               adc_retrigger,
    input  wire logic          adc_done,
    input  wire logic          adc_err,
    input  wire logic [9:0]    adc_value,
    input  wire logic [4:0]    adc_range,
    input  wire logic          batt_type,
    output logic               pass_cmd,
    output stcc_shelf_a_s      shelf_param_block_a,
    output stcc_shelf_b_s      shelf_param_block_b,
    output stcc_delay_s        delay_cfg,
    output stcc_app_s          app_cfg,
    output logic [31:0]        sys_status,
    output logic [31:0]        limit_cnt,
    output logic [2:0]         area_open,
    output logic               tx_bit,
    output logic               tx_valid,
    output logic               tx_last,
    input  wire logic          tx_ready
);
    stcc_reply_if rif ();

    stcc_state_e state_r;
    logic [7:0]  buf_r [16];
    logic [4:0]  rx_len_r;
    logic        rx_ovf_r;
    logic        rx_ok_r;
    logic [7:0]  fifo_mem [8];
    logic [2:0]  rd_ptr_r;
    logic [3:0]  fcnt_r;
    logic        src_radio_r;
    logic [31:0] ctrl_r;
    logic [31:0] pwd_r [3];
    logic [15:0] cmd_cnt_r;
    logic [71:0] payload_r;
    logic [6:0]  plen_r;
    logic [15:0] handle_r;
    logic [7:0]  last_code_r;
    logic        adc_sensor_r;

    logic [7:0]  code;
    logic [7:0]  arg;
    logic [2:0]  sub_op;
    logic [3:0]  nreq;
    logic [3:0]  nwr;
    logic [3:0]  nrd;
    logic        frame_ok;
    logic        known;
    logic        arg_ok;
    logic        accept;
    logic [31:0] pwd_rx;
    logic [71:0] rd_payload;
    logic [7:0]  fifo_stat;
    logic        exec;
    logic        apb_wr;

    function automatic logic [4:0] exp_len(input logic [7:0] c, input logic [7:0] a);
        logic [3:0] n;
        n = (a[3:0] > `STCC_FIFO_DEPTH) ? `STCC_FIFO_DEPTH : a[3:0];
        if (c == `STCC_CODE_CAL) exp_len = `STCC_FIXED_LEN;
        else if (c == `STCC_CODE_BATT || c == `STCC_CODE_SENSOR) exp_len = 5'd7;
        else if (c == `STCC_CODE_SHELF) exp_len = 5'd14;
        else if (c == `STCC_CODE_INIT) exp_len = 5'd10;
        else if (c == `STCC_CODE_OPEN) exp_len = 5'd11;
        else if (a[7:5] == `STCC_SUB_WRITE) exp_len = 5'(5'd7 + {1'b0, n});
        else exp_len = 5'd7;
    endfunction

    function automatic logic [31:0] word_at(input int i);
        word_at = {buf_r[i], buf_r[i+1], buf_r[i+2], buf_r[i+3]};
    endfunction

    always_comb begin
        code     = buf_r[1];
        arg      = buf_r[2];
        sub_op   = arg[7:5];
        nreq     = (arg[3:0] > `STCC_FIFO_DEPTH) ? `STCC_FIFO_DEPTH : arg[3:0];
        nwr      = ((`STCC_FIFO_DEPTH - fcnt_r) < nreq) ? 4'(`STCC_FIFO_DEPTH - fcnt_r) : nreq;
        nrd      = (fcnt_r < nreq) ? fcnt_r : nreq;
        pwd_rx   = word_at(3);
        frame_ok = ctrl_r[0] && rx_ok_r && !rx_ovf_r && rx_len_r >= `STCC_FIXED_LEN
                   && buf_r[0] == `STCC_PREFIX;
        known    = code >= `STCC_CODE_CAL && code <= `STCC_CODE_FIFO;
        arg_ok   = 1'b1;
        if (code == `STCC_CODE_SENSOR) begin
            arg_ok = (arg[7:2] == 6'h00);
        end else if (code == `STCC_CODE_OPEN) begin
            arg_ok = (arg[1:0] != 2'b00) && (pwd_rx == pwd_r[2'(arg[1:0] - 2'd1)]);
        end else if (code == `STCC_CODE_FIFO) begin
            arg_ok = sub_op == `STCC_SUB_READ || sub_op == `STCC_SUB_WRITE
                     || sub_op == `STCC_SUB_STAT;
        end
        accept   = frame_ok && known && arg_ok && rx_len_r == exp_len(code, arg);
        exec     = (state_r == ST_EXEC) && accept;
    end

    always_comb begin
        rd_payload = '0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < nrd) begin
                rd_payload[71-8*i -: 8] = fifo_mem[3'(rd_ptr_r + 3'(i))];
            end
        end
    end

    assign fifo_stat = {state_r != ST_IDLE, fcnt_r != 4'h0, fcnt_r == 4'h0,
                        src_radio_r, fcnt_r};
    // frame collection, only while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_len_r <= '0;
            rx_ovf_r <= 1'b0;
            rx_ok_r  <= 1'b0;
            for (int i = 0; i < 16; i++) buf_r[i] <= 8'h00;
        end else if (state_r == ST_IDLE) begin
            if (rx_end) begin
                rx_ok_r <= rx_crc_ok;
            end else if (rx_valid) begin
                if (rx_len_r == `STCC_FRAME_MAX) begin
                    rx_ovf_r <= 1'b1;
                end else begin
                    buf_r[4'(rx_len_r)] <= rx_byte;
                    rx_len_r            <= 5'(rx_len_r + 5'd1);
                end
            end
        end else if (state_r == ST_EXEC) begin
            rx_len_r <= '0;
            rx_ovf_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: if (rx_end) state_r <= ST_EXEC;
                ST_EXEC: begin
                    if (!accept) state_r <= ST_IDLE;
                    else if (code == `STCC_CODE_BATT || code == `STCC_CODE_SENSOR) state_r <= ST_ADC;
                    else state_r <= ST_GO;
                end
                ST_ADC:  if (adc_done) state_r <= ST_GO;
                ST_GO:   state_r <= ST_WAIT;
                ST_WAIT: if (!rif.busy) state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_start     <= 1'b0;
            adc_sel       <= 2'b00;
            adc_retrigger <= 1'b0;
            adc_sensor_r  <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            if (exec && code == `STCC_CODE_BATT) begin
                adc_start     <= 1'b1;
                adc_sel       <= `STCC_SEL_BATT;
                adc_retrigger <= (arg == `STCC_RETRIG_REQ);
                adc_sensor_r  <= 1'b0;
            end else if (exec && code == `STCC_CODE_SENSOR) begin
                adc_start     <= 1'b1;
                adc_sel       <= arg[1:0];
                adc_retrigger <= 1'b0;
                adc_sensor_r  <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            payload_r   <= '0;
            plen_r      <= '0;
            handle_r    <= '0;
            last_code_r <= 8'h00;
        end else if (exec) begin
            handle_r    <= {buf_r[4'(rx_len_r - `STCC_TRAILER_LEN)],
                            buf_r[4'(rx_len_r - 5'd3)]};
            last_code_r <= code;
            payload_r   <= '0;
            plen_r      <= 7'd0;
            if (code == `STCC_CODE_CAL) begin
                payload_r <= {cal_data, sfe_params};
                plen_r    <= 7'd72;
            end else if (code == `STCC_CODE_FIFO && sub_op == `STCC_SUB_STAT) begin
                payload_r <= {fifo_stat, 64'h0};
                plen_r    <= 7'd8;
            end else if (code == `STCC_CODE_FIFO && sub_op == `STCC_SUB_READ) begin
                payload_r <= rd_payload;
                plen_r    <= 7'({nrd, 3'b000});
            end
        end else if (state_r == ST_ADC && adc_done) begin
            plen_r <= 7'd16;
            if (adc_sensor_r) begin
                payload_r <= {adc_err, adc_range, adc_value, 56'h0};
            end else begin
                payload_r <= {adc_err, batt_type, 4'b0000, adc_value, 56'h0};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_r    <= '0;
            fcnt_r      <= '0;
            src_radio_r <= 1'b0;
            for (int i = 0; i < 8; i++) fifo_mem[i] <= 8'h00;
        end else if (exec && code == `STCC_CODE_FIFO) begin
            if (sub_op == `STCC_SUB_WRITE) begin
                for (int i = 0; i < 8; i++) begin
                    if (4'(i) < nwr) begin
                        fifo_mem[3'(rd_ptr_r + fcnt_r[2:0] + 3'(i))] <= buf_r[3+i];
                    end
                end
                fcnt_r      <= 4'(fcnt_r + nwr);
                src_radio_r <= (nwr != 4'h0) ? 1'b1 : src_radio_r;
            end else if (sub_op == `STCC_SUB_READ) begin
                rd_ptr_r <= 3'(rd_ptr_r + nrd[2:0]);
                fcnt_r   <= 4'(fcnt_r - nrd);
            end
        end
    end
    // logging and shelf-life parameters; hardware clear wins over software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shelf_param_block_a <= '0;
            shelf_param_block_b <= '0;
            delay_cfg           <= '0;
            app_cfg             <= '0;
            sys_status          <= '0;
            limit_cnt           <= '0;
        end else if (exec && code == `STCC_CODE_SHELF) begin
            shelf_param_block_a <= word_at(2);
            shelf_param_block_b <= word_at(6);
        end else if (exec && code == `STCC_CODE_INIT) begin
            sys_status <= '0;
            limit_cnt  <= '0;
            delay_cfg  <= {buf_r[2], buf_r[3]};
            app_cfg    <= {buf_r[4], buf_r[5]};
        end else if (apb_wr && paddr == `STCC_OFF_SYSSTAT) begin
            sys_status <= pwdata;
        end else if (apb_wr && paddr == `STCC_OFF_LIMIT) begin
            limit_cnt <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            area_open <= 3'b000;
        end else if (exec && code == `STCC_CODE_OPEN) begin
            area_open[2'(arg[1:0] - 2'd1)] <= 1'b1;
        end else if (apb_wr && paddr == `STCC_OFF_CTRL && pwdata[1]) begin
            area_open <= 3'b000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pass_cmd  <= 1'b0;
            cmd_cnt_r <= '0;
        end else begin
            pass_cmd <= (state_r == ST_EXEC) && frame_ok && !known;
            if (state_r == ST_GO) begin
                cmd_cnt_r <= 16'(cmd_cnt_r + 16'd1);
            end
        end
    end

    assign rif.start   = (state_r == ST_GO);
    assign rif.payload = payload_r;
    assign rif.plen    = plen_r;
    assign rif.handle  = handle_r;

    stcc_reply_tx u_tx (
        .pclk     (pclk),
        .presetn  (presetn),
        .rif      (rif),
        .tx_bit   (tx_bit),
        .tx_valid (tx_valid),
        .tx_last  (tx_last),
        .tx_ready (tx_ready)
    );

    // apb slave, zero wait states
    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `STCC_CTRL_RST;
            for (int i = 0; i < 3; i++) pwd_r[i] <= `STCC_PWD_RST;
        end else if (apb_wr) begin
            if (paddr == `STCC_OFF_CTRL) ctrl_r <= {31'h0, pwdata[0]};
            else if (paddr == `STCC_OFF_PWD_SYS) pwd_r[0] <= pwdata;
            else if (paddr == `STCC_OFF_PWD_APP) pwd_r[1] <= pwdata;
            else if (paddr == `STCC_OFF_PWD_MEAS) pwd_r[2] <= pwdata;
        end
    end

    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == `STCC_OFF_CTRL) prdata = ctrl_r;
        else if (paddr == `STCC_OFF_STAT)
            prdata = {5'h00, state_r, last_code_r, 5'h00, area_open, fifo_stat};
        else if (paddr == `STCC_OFF_SHELF_A) prdata = shelf_param_block_a;
        else if (paddr == `STCC_OFF_SHELF_B) prdata = shelf_param_block_b;
        else if (paddr == `STCC_OFF_LOGCFG) prdata = {delay_cfg, app_cfg};
        else if (paddr == `STCC_OFF_SYSSTAT) prdata = sys_status;
        else if (paddr == `STCC_OFF_LIMIT) prdata = limit_cnt;
        else if (paddr == `STCC_OFF_CMDCNT) prdata = {16'h0000, cmd_cnt_r};
        else if (paddr == `STCC_OFF_PWD_SYS || paddr == `STCC_OFF_PWD_APP
                 || paddr == `STCC_OFF_PWD_MEAS) prdata = 32'h0000_0000;
        else pslverr = psel && penable;
    end
endmodule // stcc_cmd

/* File: bench/stcc_cmd_props.sv */
// assertions on the command interpreter ports
`timescale 1ns/100ps
module stcc_cmd_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic adc_start,
    input wire logic adc_done,
    input wire logic pass_cmd,
    input wire logic tx_bit,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic tx_ready
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_hdr; $rose(tx_valid) |-> !tx_bit; endproperty
    a_hdr: assert property (p_hdr) else $error("header bit not zero");
    property p_dummy; tx_last |-> tx_valid && tx_bit; endproperty
    a_dummy: assert property (p_dummy) else $error("dummy bit not one");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_bit); endproperty
    a_hold: assert property (p_hold) else $error("reply bit dropped");
    property p_end; tx_last && tx_ready |=> !tx_valid; endproperty
    a_end: assert property (p_end) else $error("reply runs past dummy");
    property p_adc; adc_start |=> !adc_start; endproperty
    a_adc: assert property (p_adc) else $error("start not a pulse");
    property p_first; adc_start |-> !tx_valid; endproperty
    a_first: assert property (p_first) else $error("reply before conversion");
    property p_after; adc_done |-> ##[1:3] $rose(tx_valid); endproperty
    a_after: assert property (p_after) else $error("no reply after conversion");
    property p_pass; pass_cmd |=> (!pass_cmd && !tx_valid) [*6]; endproperty
    a_pass: assert property (p_pass) else $error("forwarded code answered");
    c_reply: cover property (tx_last && tx_ready);
    c_conv: cover property (adc_done);
    c_pass: cover property (pass_cmd);
endmodule // stcc_cmd_props

/* File: bench/stcc_reader_model.sv */
// reader model: sends framed bytes, takes reply bits slowly
`timescale 1ns/100ps
module stcc_reader_model #(
    parameter logic [15:0] HANDLE = 16'h5a3c,
    parameter bit          SLOW   = 1'b1
) (
    input  wire logic       pclk,
    output logic [7:0]      rx_byte,
    output logic            rx_valid,
    output logic            rx_end,
    output logic            rx_crc_ok,
    input  wire logic       tx_bit,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    logic bits[$];
    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        rx_end = 1'b0;
        rx_crc_ok = 1'b0;
        tx_ready = 1'b0;
    end
    always @(posedge pclk) begin
        tx_ready <= SLOW ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready) bits.push_back(tx_bit);
    end
    task automatic send(input logic [127:0] f, input int n);
        logic [159:0] w;
        w = {f, 32'h0};
        w[159 - 8 * n -: 32] = {HANDLE, 16'hc35a};
        bits.delete();
        for (int i = 0; i < n + 4; i++) begin
            @(posedge pclk);
            rx_byte <= w[159 - 8 * i -: 8];
            rx_valid <= 1'b1;
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        rx_end <= 1'b1;
        rx_crc_ok <= 1'b1;
        @(posedge pclk);
        rx_end <= 1'b0;
        rx_crc_ok <= 1'b0;
    endtask
endmodule // stcc_reader_model

/* File: bench/tb_stcc_cmd.sv */
// bench for the custom command interpreter
`timescale 1ns/100ps
module tb_stcc_cmd;
    import stcc_pkg::*;
    localparam logic [15:0] HANDLE = 16'h5a3c;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, rx_byte;
    logic [31:0] pwdata = 32'h0, prdata, rd, sys_status, limit_cnt;
    logic        pready, pslverr, er, rx_valid, rx_end, rx_crc_ok, adc_start, adc_retrigger;
    logic        adc_done = 1'b0, pass_cmd, pass_seen = 1'b0, rt_seen, tx_bit, tx_valid;
    logic        tx_last, tx_ready;
    logic [55:0] cal_data = 56'h0123456789abcd;
    logic [15:0] sfe_params = 16'hbeef;
    logic [1:0]  adc_sel, sel_seen;
    logic [2:0]  area_open;
    stcc_shelf_a_s sa;
    stcc_shelf_b_s sb;
    stcc_delay_s   dc;
    stcc_app_s     ac;
    int          n_errors = 0, n_checks = 0;
    stcc_cmd dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rx_byte, .rx_valid, .rx_end, .rx_crc_ok, .cal_data, .sfe_params, .adc_start, .adc_sel,
        .adc_retrigger, .adc_done, .adc_err(1'b0), .adc_value(10'h2b5),
        .adc_range({3'b101, adc_sel}), .batt_type(1'b1), .pass_cmd, .shelf_param_block_a(sa),
        .shelf_param_block_b(sb), .delay_cfg(dc), .app_cfg(ac), .sys_status, .limit_cnt,
        .area_open, .tx_bit, .tx_valid, .tx_last, .tx_ready
    );
    stcc_reader_model #(.HANDLE(HANDLE), .SLOW(1'b1)) rdr (
        .pclk, .rx_byte, .rx_valid, .rx_end, .rx_crc_ok, .tx_bit, .tx_valid, .tx_last, .tx_ready
    );
    always #4 pclk = ~pclk;
    // stand-in converter answers one cycle after each start
    always @(posedge pclk) begin
        adc_done <= adc_start;
        if (adc_start) sel_seen <= adc_sel;
        if (adc_start) rt_seen <= adc_retrigger;
        if (pass_cmd) pass_seen <= 1'b1;
    end
    task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
        n_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [127:0] f, input int n, input logic [71:0] p, input int pl);
        int k = 0;
        logic [71:0] gp = '0;
        logic [15:0] gh = '0;
        rdr.send(f, n);
        while (rdr.bits.size() < pl + 34 && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        repeat (3) @(posedge pclk);
        for (int i = 0; i < pl; i++) gp[71 - i] = rdr.bits[1 + i];
        for (int i = 0; i < 16; i++) gh[15 - i] = rdr.bits[1 + pl + i];
        chk("length", pl + 34, rdr.bits.size());
        chk("header", 0, rdr.bits[0]);
        chk("payload", p, gp);
        chk("handle", HANDLE, gh);
        chk("dummy", 1, rdr.bits[pl + 33]);
    endtask
    task automatic stop_test();
        if (n_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge pclk);
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h40, 0);
        chk("slverr", 1, er);
        cmd({8'he0, 8'ha9, 112'h0}, 2, {cal_data, sfe_params}, 72);
        for (int t = 1; t >= 0; t--) begin
            cmd({8'he0, 8'haa, 7'h0, t[0], 104'h0}, 3, {6'h10, 10'h2b5, 56'h0}, 16);
            chk("batt_sel", 3, sel_seen);
            chk("retrigger", t, rt_seen);
        end
        cmd({8'he0, 8'hab, 64'h7f10_1922_1234_a5bd, 48'h0}, 10, 0, 0);
        chk("shelf_a", 32'h7f101922, {sa.t_max, sa.t_min, sa.t_ref, sa.activation_energy});
        chk("shelf_b", {16'h1234, 10'h296, 4'hf}, {sb.initial_shelf_life, sb.t_init,
            sb.sensor_sel, sb.neg_life_en, sb.algo_en});
        apb(1, 8'h14, 32'hdeadbeef);
        apb(1, 8'h18, 32'h01020304);
        cmd({8'he0, 8'hac, 32'habc6_0f85, 80'h0}, 6, 0, 0);
        chk("cleared", 0, {sys_status, limit_cnt});
        chk("delay", {12'habc, 2'b10}, {dc.delay_count, dc.delay_src, dc.irq_timer_en});
        chk("app", {9'h01f, 3'h5}, {ac.app_words, ac.broken_ptr});
        for (int s = 0; s < 4; s++) begin
            cmd({8'he0, 8'had, 6'h0, s[1:0], 104'h0}, 3, {4'h5, s[1:0], 10'h2b5, 56'h0}, 16);
            chk("sensor_sel", s, sel_seen);
        end
        apb(1, 8'h20, 32'hcafef00d);
        cmd({8'he0, 8'hae, 8'hfe, 32'hcafef00d, 72'h0}, 7, 0, 0);
        chk("area", 3'b010, area_open);
        cmd({8'he0, 8'haf, 8'ha3, 24'h112233, 80'h0}, 6, 0, 0);
        cmd({8'he0, 8'haf, 8'h82, 104'h0}, 3, {16'h1122, 56'h0}, 16);
        cmd({8'he0, 8'haf, 8'hc0, 104'h0}, 3, {8'hd1, 64'h0}, 8);
        apb(0, 8'h04, 0);
        chk("fifo_stat", 5'h11, rd[4:0]);
        rdr.send({8'he0, 8'had, 8'h41, 104'h0}, 3);
        repeat (20) @(posedge pclk);
        chk("bad_sensor", 0, rdr.bits.size());
        rdr.send({8'he0, 8'ha4, 112'h0}, 2);
        repeat (20) @(posedge pclk);
        chk("pass", 2'b11, {pass_seen, rdr.bits.size() == 0});
        stop_test();
    end
endmodule // tb_stcc_cmd
bind stcc_cmd stcc_cmd_props chk_u (
    .pclk, .presetn, .adc_start, .adc_done, .pass_cmd, .tx_bit, .tx_valid, .tx_last, .tx_ready
);
